/* design/cdb_cfg.svh */
`ifndef CDB_CFG_SVH
`define CDB_CFG_SVH

// Configuration space word addresses
`define CDB_ADDR_POWER_ON   24'hF8_000C
`define CDB_ADDR_DEBUG      24'hF8_000E
`define CDB_ADDR_UNIT0      24'hF8_0010
`define CDB_ADDR_UNIT1      24'hF8_0012
`define CDB_ADDR_UNIT2      24'hF8_0014
`define CDB_ADDR_UNIT3      24'hF8_0016
`define CDB_ADDR_CMP        24'hF8_0018
`define CDB_ADDR_ID_LOW     24'hFF_0000
`define CDB_ADDR_ID_HIGH    24'hFF_0002

// Implemented bits per word; everything else reads zero
`define CDB_MASK_POWER_ON   24'h00_00FF
`define CDB_MASK_DEBUG      24'h00_00E3
`define CDB_MASK_CMP        24'h00_003F
`define CDB_MASK_UNIT       24'hFF_FFFF
`define CDB_ERASED          24'hFF_FFFF

// Field positions
`define CDB_BIT_PORT_EN     5
`define CDB_CHAN_HI         1
`define CDB_CHAN_LO         0
`define CDB_BIT_ODD_POL     5
`define CDB_ODD_AMT_HI      4
`define CDB_ODD_AMT_LO      3
`define CDB_BIT_EVEN_POL    2
`define CDB_EVEN_AMT_HI     1
`define CDB_EVEN_AMT_LO     0
`define CDB_BIT_PWM_PORT    7
`define CDB_BIT_PWM_HIGH    6
`define CDB_BIT_PWM_LOW     5

// Channel select codes
`define CDB_CHAN_PAIR1      2'h3
`define CDB_CHAN_PAIR2      2'h2
`define CDB_CHAN_PAIR3      2'h1

// Hysteresis in mV per amount code
`define CDB_HYST_MV_3       6'h2D
`define CDB_HYST_MV_2       6'h1E
`define CDB_HYST_MV_1       6'h0F
`define CDB_HYST_MV_0       6'h00

// Data RAM bytes held back while debugging (80)
`define CDB_DBG_RAM_BYTES   7'h50

// Link clocks between a read address and the first reply bit
`define CDB_TURN_CLKS       8

`endif

/* design/cdb_pkg.sv */
package cdb_pkg;

  typedef logic [23:0] cdb_word_t;
  typedef logic [1:0]  cdb_pair_t;

  // Serial link frame states
  typedef enum logic [5:0] {
    CDB_ST_IDLE  = 6'b00_0001,
    CDB_ST_OP    = 6'b00_0010,
    CDB_ST_ADDR  = 6'b00_0100,
    CDB_ST_WDATA = 6'b00_1000,
    CDB_ST_TURN  = 6'b01_0000,
    CDB_ST_RDATA = 6'b10_0000
  } cdb_link_state_t;

endpackage

/* design/cdb_config_bank.sv */
// Behaviour
// [R1] Channel code 11 first pair, 10 second
// [R2] Debug word bits 7-6 reserved, unused
// [R3] Bit 5 of debug word enables boundary port
// [R4] Odd comparators: bit 5 picks hysteresis edge
// [R5] Even comparators: bit 2 picks hysteresis edge
// [R6] Amount codes give 45/30/15/0 mV
// [R7] Comparator word bits 23-6 read zero
// [R8] Part identity read-only at two addresses
// [R9] Four writable unit info words
// [R10] Debugging reserves 80 RAM bytes, two pins
// [R11] Programming accepted on any pin pair
// [R12] Programmer clocks; data pin is two-way
// [R13] Power-on bits set PWM pin state, polarity
// [R14] Unimplemented bit writes ignored, read zero
`timescale 1ns/1ps
`include "cdb_cfg.svh"

module cdb_config_bank #(
  parameter cdb_pkg::cdb_word_t PART_ID_LOW  = 24'h00_1234,
  parameter cdb_pkg::cdb_word_t PART_ID_HIGH = 24'h00_0001,
  parameter int                 TURN_CLKS    = `CDB_TURN_CLKS
) (
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               tbl_rd_i,
  input  wire cdb_pkg::cdb_word_t tbl_addr_i,
  output cdb_pkg::cdb_word_t      tbl_rdata_o,
  output logic                    tbl_rvalid_o,
  input  wire logic               debug_mode_i,
  input  wire logic               prog_debug_clock_pin_i,
  input  wire logic [2:0]         prog_debug_data_pin_i,
  output logic [2:0]              prog_debug_data_pin_o,
  output logic [2:0]              prog_debug_data_pin_oe_o,
  output logic                    boundary_port_enable_o,
  output logic [1:0]              debug_channel_select_o,
  output logic [2:0]              debug_pin_reserve_o,
  output logic [6:0]              debug_ram_limit_o,
  output logic                    odd_hyst_edge_select_o,
  output logic [1:0]              odd_hyst_amount_o,
  output logic [5:0]              odd_hyst_mv_o,
  output logic                    even_hyst_edge_select_o,
  output logic [1:0]              even_hyst_amount_o,
  output logic [5:0]              even_hyst_mv_o,
  output logic                    pwm_pins_port_ctrl_o,
  output logic                    pwm_high_active_high_o,
  output logic                    pwm_low_active_high_o
);
  import cdb_pkg::*;

  localparam int NREG = 7;
  localparam int IDX_POWER = 0;
  localparam int IDX_DEBUG = 1;
  localparam int IDX_CMP = 2;
  localparam logic [3:0] TURN_LAST = 4'(TURN_CLKS - 1);

  // Reply must not start before the handshake can have returned
  if (TURN_CLKS < 4 || TURN_CLKS > 15) begin : g_bad_turn
    $error("TURN_CLKS must lie in 4..15");
  end

  // Word address of each stored register
  function automatic cdb_word_t reg_addr(input int i);
    case (i)
      0:       return `CDB_ADDR_POWER_ON;
      1:       return `CDB_ADDR_DEBUG;
      2:       return `CDB_ADDR_CMP;
      3:       return `CDB_ADDR_UNIT0;
      4:       return `CDB_ADDR_UNIT1;
      5:       return `CDB_ADDR_UNIT2;
      default: return `CDB_ADDR_UNIT3;
    endcase
  endfunction

  // Implemented bits of each stored register
  function automatic cdb_word_t mask_of(input int i);
    case (i)
      0:       return `CDB_MASK_POWER_ON;
      1:       return `CDB_MASK_DEBUG;
      2:       return `CDB_MASK_CMP;
      default: return `CDB_MASK_UNIT;
    endcase
  endfunction

  cdb_word_t       cfg_q [NREG];
  logic [NREG-1:0] tbl_sel;
  logic [NREG-1:0] hold_sel;
  cdb_word_t       hold_addr;
  cdb_word_t       hold_data;
  logic            hold_op;
  cdb_word_t       tbl_word;
  cdb_word_t       hold_word;

  // Address decode for both the table port and the link request
  for (genvar i = 0; i < NREG; i++) begin : g_dec
    assign tbl_sel[i]  = (tbl_addr_i == reg_addr(i));
    assign hold_sel[i] = (hold_addr == reg_addr(i));
  end

  // Read mux; part identity is fixed and unmapped words read zero
  always_comb begin
    tbl_word  = '0;
    hold_word = '0;
    for (int i = 0; i < NREG; i++) begin
      if (tbl_sel[i]) tbl_word = cfg_q[i];
      if (hold_sel[i]) hold_word = cfg_q[i];
    end
    if (tbl_addr_i == `CDB_ADDR_ID_LOW) tbl_word = PART_ID_LOW;    // [R8]
    if (tbl_addr_i == `CDB_ADDR_ID_HIGH) tbl_word = PART_ID_HIGH;  // [R8]
    if (hold_addr == `CDB_ADDR_ID_LOW) hold_word = PART_ID_LOW;    // [R8]
    if (hold_addr == `CDB_ADDR_ID_HIGH) hold_word = PART_ID_HIGH;  // [R8]
  end

  // ---------------- Link domain ----------------
  logic [1:0]      lrst_sync;
  logic            link_rst;
  logic            dbg_s1, dbg_s2;
  logic [1:0]      chan_s1, chan_s2;
  logic            ack_s1, ack_s2;
  logic            req_tog;
  cdb_link_state_t state;
  logic [4:0]      bit_cnt;
  logic [3:0]      turn_cnt;
  cdb_pair_t       pair_q;
  logic            op_q;
  cdb_word_t       addr_q;
  cdb_word_t       shift_q;
  logic            drive_q;
  logic [2:0]      elig;
  logic            start_hit;
  cdb_pair_t       start_pair;
  logic            din;
  logic            sel_valid;
  cdb_pair_t       sel_pair;
  cdb_word_t       rd_word_core;
  logic            ack_tog;

  // Reset, debug mode and channel code are brought into the link clock
  always_ff @(posedge prog_debug_clock_pin_i) begin
    lrst_sync <= {lrst_sync[0], sys_rst_i};
    dbg_s1    <= debug_mode_i;
    dbg_s2    <= dbg_s1;
    chan_s1   <= cfg_q[IDX_DEBUG][`CDB_CHAN_HI:`CDB_CHAN_LO];
    chan_s2   <= chan_s1;
    ack_s1    <= ack_tog;
    ack_s2    <= ack_s1;
  end
  assign link_rst = lrst_sync[1];

  // Channel code to pin pair; code 00 leaves no pair for the debugger
  assign sel_valid = (chan_s2 != 2'h0);
  assign sel_pair  = (chan_s2 == `CDB_CHAN_PAIR1) ? 2'h0 :                     // [R1]
                     (chan_s2 == `CDB_CHAN_PAIR2) ? 2'h1 : 2'h2;               // [R1]

  // Programming listens on every pair, debugging only on the chosen one
  for (genvar p = 0; p < 3; p++) begin : g_pair
    assign elig[p] = !dbg_s2 || (sel_valid && sel_pair == 2'(p));              // [R11] [R1]
    assign prog_debug_data_pin_oe_o[p] = drive_q && (pair_q == 2'(p));         // [R12]
    assign prog_debug_data_pin_o[p]    = shift_q[23];
  end
  assign start_hit  = |(prog_debug_data_pin_i & elig);
  assign start_pair = (prog_debug_data_pin_i[0] && elig[0]) ? 2'h0 :
                      (prog_debug_data_pin_i[1] && elig[1]) ? 2'h1 : 2'h2;
  assign din        = prog_debug_data_pin_i[pair_q];

  // Frame: start bit, op bit, 24 address bits, then 24 data bits in or out
  always_ff @(posedge prog_debug_clock_pin_i) begin
    if (link_rst) begin
      state    <= CDB_ST_IDLE;
      bit_cnt  <= 5'h00;
      turn_cnt <= 4'h0;
      pair_q   <= 2'h0;
      op_q     <= 1'b0;
      addr_q   <= '0;
      shift_q  <= '0;
      drive_q  <= 1'b0;
      req_tog  <= 1'b0;
      hold_op  <= 1'b0;
      hold_addr <= '0;
      hold_data <= '0;
    end else begin
      unique case (state)
        CDB_ST_IDLE: if (start_hit) begin
          pair_q <= start_pair;                                                // [R11]
          state  <= CDB_ST_OP;
        end
        CDB_ST_OP: begin
          op_q    <= din;
          bit_cnt <= 5'h17;
          state   <= CDB_ST_ADDR;
        end
        CDB_ST_ADDR: begin
          addr_q  <= {addr_q[22:0], din};
          bit_cnt <= bit_cnt - 5'h01;
          if (bit_cnt == 5'h00) begin
            bit_cnt <= 5'h17;
            if (op_q) begin
              state <= CDB_ST_WDATA;
            end else begin
              hold_op   <= 1'b0;
              hold_addr <= {addr_q[22:0], din};
              req_tog   <= ~req_tog;
              turn_cnt  <= 4'h0;
              state     <= CDB_ST_TURN;
            end
          end
        end
        CDB_ST_WDATA: begin
          shift_q <= {shift_q[22:0], din};                                     // [R12]
          bit_cnt <= bit_cnt - 5'h01;
          if (bit_cnt == 5'h00) begin
            hold_op   <= 1'b1;
            hold_addr <= addr_q;
            hold_data <= {shift_q[22:0], din};
            req_tog   <= ~req_tog;
            state     <= CDB_ST_IDLE;
          end
        end
        CDB_ST_TURN: begin
          // Waits on past the turnaround if the core has not answered yet
          if (turn_cnt != TURN_LAST) begin
            turn_cnt <= turn_cnt + 4'h1;
          end else if (ack_s2 == req_tog) begin
            shift_q <= rd_word_core;
            bit_cnt <= 5'h17;
            drive_q <= 1'b1;                                                   // [R12]
            state   <= CDB_ST_RDATA;
          end
        end
        CDB_ST_RDATA: begin
          shift_q <= {shift_q[22:0], 1'b0};
          bit_cnt <= bit_cnt - 5'h01;
          if (bit_cnt == 5'h00) begin
            drive_q <= 1'b0;
            state   <= CDB_ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- Core domain ----------------
  logic [2:0] req_s;
  logic       req_ev;
  logic       wr_ev;

  // Toggle handshake; hold_* stay still until the next request toggles req_tog
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      req_s        <= 3'h0;
      ack_tog      <= 1'b0;
      rd_word_core <= '0;
    end else begin
      req_s <= {req_s[1:0], req_tog};
      if (req_ev) begin
        ack_tog <= ~ack_tog;
        if (!hold_op) rd_word_core <= hold_word;
      end
    end
  end
  assign req_ev = req_s[1] ^ req_s[2];
  assign wr_ev  = req_ev && hold_op;

  // Stored words; identity has no storage so writes to it fall away
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        cfg_q[i] <= `CDB_ERASED & mask_of(i);
      end else if (wr_ev && hold_sel[i]) begin
        cfg_q[i] <= hold_data & mask_of(i);                                    // [R14] [R7] [R9]
      end
    end
  end

  // Table reads answer one cycle after the request
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tbl_rvalid_o <= 1'b0;
      tbl_rdata_o  <= '0;
    end else begin
      tbl_rvalid_o <= tbl_rd_i;
      if (tbl_rd_i) tbl_rdata_o <= tbl_word;
    end
  end

  logic [1:0] odd_amt;
  logic [1:0] even_amt;
  logic [1:0] chan_code;
  assign odd_amt   = cfg_q[IDX_CMP][`CDB_ODD_AMT_HI:`CDB_ODD_AMT_LO];
  assign even_amt  = cfg_q[IDX_CMP][`CDB_EVEN_AMT_HI:`CDB_EVEN_AMT_LO];
  assign chan_code = cfg_q[IDX_DEBUG][`CDB_CHAN_HI:`CDB_CHAN_LO];

  function automatic logic [5:0] hyst_mv(input logic [1:0] code);
    case (code)
      2'h3:    return `CDB_HYST_MV_3;
      2'h2:    return `CDB_HYST_MV_2;
      2'h1:    return `CDB_HYST_MV_1;
      default: return `CDB_HYST_MV_0;
    endcase
  endfunction

  // Decoded settings, registered so the consumers see clean levels
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      boundary_port_enable_o  <= 1'b0;
      debug_channel_select_o  <= 2'h0;
      debug_pin_reserve_o     <= 3'h0;
      debug_ram_limit_o       <= 7'h00;
      odd_hyst_edge_select_o  <= 1'b0;
      odd_hyst_amount_o       <= 2'h0;
      odd_hyst_mv_o           <= 6'h00;
      even_hyst_edge_select_o <= 1'b0;
      even_hyst_amount_o      <= 2'h0;
      even_hyst_mv_o          <= 6'h00;
      pwm_pins_port_ctrl_o    <= 1'b0;
      pwm_high_active_high_o  <= 1'b0;
      pwm_low_active_high_o   <= 1'b0;
    end else begin
      boundary_port_enable_o  <= cfg_q[IDX_DEBUG][`CDB_BIT_PORT_EN];              // [R3]
      debug_channel_select_o  <= chan_code;                                       // [R1]
      debug_pin_reserve_o     <= debug_mode_i ? {chan_code == `CDB_CHAN_PAIR3,
                                                 chan_code == `CDB_CHAN_PAIR2,
                                                 chan_code == `CDB_CHAN_PAIR1} : 3'h0; // [R10]
      debug_ram_limit_o       <= debug_mode_i ? `CDB_DBG_RAM_BYTES : 7'h00;      // [R10]
      odd_hyst_edge_select_o  <= cfg_q[IDX_CMP][`CDB_BIT_ODD_POL];                // [R4]
      odd_hyst_amount_o       <= odd_amt;
      odd_hyst_mv_o           <= hyst_mv(odd_amt);                                // [R6]
      even_hyst_edge_select_o <= cfg_q[IDX_CMP][`CDB_BIT_EVEN_POL];               // [R5]
      even_hyst_amount_o      <= even_amt;
      even_hyst_mv_o          <= hyst_mv(even_amt);                               // [R6]
      pwm_pins_port_ctrl_o    <= cfg_q[IDX_POWER][`CDB_BIT_PWM_PORT];             // [R13]
      pwm_high_active_high_o  <= cfg_q[IDX_POWER][`CDB_BIT_PWM_HIGH];             // [R13]
      pwm_low_active_high_o   <= cfg_q[IDX_POWER][`CDB_BIT_PWM_LOW];              // [R13]
    end
  end

  // ---------------- Checks ----------------
  chk_port_enable_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R3]
    wr_ev && hold_sel[IDX_DEBUG] |-> ##2 boundary_port_enable_o == $past(hold_data[5], 2))
    else $error("boundary port enable does not follow written bit");
  chk_cmp_upper_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R7]
    tbl_rvalid_o && $past(tbl_addr_i) == `CDB_ADDR_CMP |-> tbl_rdata_o[23:6] == 18'h0_0000)
    else $error("comparator word upper bits not zero");
  chk_odd_hyst_mv: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R6]
    !sys_rst_i && $stable(odd_amt) && odd_amt == 2'h3 |=> odd_hyst_mv_o == 6'h2D)
    else $error("odd hysteresis code 11 not 45 mV");
  chk_even_edge_sel: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R5]
    wr_ev && hold_sel[IDX_CMP] |-> ##2 even_hyst_edge_select_o == $past(hold_data[2], 2))
    else $error("even edge select does not follow bit 2");
  chk_odd_edge_sel: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R4]
    wr_ev && hold_sel[IDX_CMP] |-> ##2 odd_hyst_edge_select_o == $past(hold_data[5], 2))
    else $error("odd edge select does not follow bit 5");
  chk_id_read_only: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R8]
    tbl_rvalid_o && $past(tbl_addr_i) == `CDB_ADDR_ID_HIGH |-> tbl_rdata_o == PART_ID_HIGH)
    else $error("part identity high word wrong");
  chk_unit_word_store: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R9]
    wr_ev && hold_sel[6] |=> cfg_q[6] == $past(hold_data))
    else $error("unit info word 3 did not store write");
  chk_ram_reserve: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R10]
    (debug_mode_i && !sys_rst_i) [*2] |-> debug_ram_limit_o == 7'h50)
    else $error("debug RAM reservation not 80 bytes");
  chk_debug_pair_only: assert property (@(posedge prog_debug_clock_pin_i) disable iff (link_rst) // [R1]
    dbg_s2 && $stable(dbg_s2) && sel_valid && $rose(drive_q) |-> pair_q == sel_pair)
    else $error("debugger replied on a pair other than the selected one");
  chk_reply_length: assert property (@(posedge prog_debug_clock_pin_i) disable iff (link_rst) // [R12]
    $rose(drive_q) |-> drive_q [*8] ##17 !drive_q)
    else $error("read reply not 24 clocks long");

  cov_link_write: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) wr_ev);
  cov_link_read: cover property (@(posedge prog_debug_clock_pin_i) disable iff (link_rst) $rose(drive_q));
  cov_table_cmp: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tbl_rvalid_o && $past(tbl_addr_i) == `CDB_ADDR_CMP);
  cov_debug_mode: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) debug_mode_i);

endmodule

/* verification/cdb_prog_model.sv */
`timescale 1ns/1ps
module cdb_prog_model (
  output logic            link_clk_o,
  output logic [2:0]      host_data_o,
  input  wire logic [2:0] pin_data_i,
  input  wire logic [2:0] dev_oe_i
);
  // Clock rests low and pins idle low until a frame is sent
  initial begin
    link_clk_o  = 1'b0;
    host_data_o = 3'b000;
  end

  // The device samples on the rise, so data only moves after the fall
  task automatic tick();
    #32 link_clk_o = 1'b1;
    #32 link_clk_o = 1'b0;
  endtask

  // Low data keeps every pair idle, so no start bit is seen
  task automatic idle(input int n);
    host_data_o = 3'b000;
    repeat (n) tick();
  endtask

  task automatic put(input int pair, input logic b);
    host_data_o[pair] = b;
    tick();
  endtask

  // Lead-in clocks let the link side settle before the start bit
  task automatic head(input int pair, input logic op, input logic [23:0] addr);
    idle(3);
    put(pair, 1'b1);
    put(pair, op);
    for (int i = 23; i >= 0; i--) begin
      put(pair, addr[i]);
    end
  endtask

  task automatic frame_write(input int pair, input logic [23:0] addr, input logic [23:0] data);
    head(pair, 1'b1, addr);
    for (int i = 23; i >= 0; i--) begin
      put(pair, data[i]);
    end
    idle(3);
  endtask

  // Released pin toggles every clock so a stale level is never read back
  task automatic frame_read(input int pair, input logic [23:0] addr, output logic [23:0] data,
                            output int oe_clks);
    data    = 24'h00_0000;
    oe_clks = 0;
    head(pair, 1'b0, addr);
    for (int n = 0; n < 60 && (oe_clks == 0 || dev_oe_i[pair]); n++) begin
      host_data_o[pair] = ~host_data_o[pair];
      #32 link_clk_o = 1'b1;
      #16;
      if (dev_oe_i[pair] === 1'b1) begin
        data = {data[22:0], pin_data_i[pair]};
        oe_clks++;
      end
      #16 link_clk_o = 1'b0;
    end
    idle(3);
  endtask
endmodule

/* verification/tb_config_debug_comparator_bank.sv */
`timescale 1ns/1ps
`include "cdb_cfg.svh"
module tb_config_debug_comparator_bank;
  import cdb_pkg::*;
  localparam cdb_word_t ID_LO = 24'h00_0A5C; // Arbitrary value
  localparam cdb_word_t ID_HI = 24'h00_0003; // Arbitrary value
  logic       core_clk;
  logic       sys_rst;
  logic       tbl_rd;
  cdb_word_t  tbl_addr;
  cdb_word_t  tbl_rdata;
  logic       tbl_rvalid;
  logic       dbg_mode;
  logic       link_clk;
  logic [2:0] host_d;
  logic [2:0] pin_in;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  logic       port_en;
  logic [1:0] chan;
  logic [2:0] pin_res;
  logic [6:0] ram_lim;
  logic       odd_edge;
  logic [1:0] odd_amt;
  logic [5:0] odd_mv;
  logic       even_edge;
  logic [1:0] even_amt;
  logic [5:0] even_mv;
  logic [2:0] pwm;
  int         n_fail;
  int         cmp_count;
  int         oe_clks;
  cdb_word_t  wd;
  cdb_word_t  wc;
  logic [5:0] mv_tab [4] = '{6'h00, 6'h0F, 6'h1E, 6'h2D}; // 0, 15, 30, 45 mV

  // Data pin level: the device wins while its enable is high
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & host_d);

  cdb_config_bank #(.PART_ID_LOW(ID_LO), .PART_ID_HIGH(ID_HI), .TURN_CLKS(`CDB_TURN_CLKS)) dut (
    .core_clk_i              (core_clk),
    .sys_rst_i               (sys_rst),
    .tbl_rd_i                (tbl_rd),
    .tbl_addr_i              (tbl_addr),
    .tbl_rdata_o             (tbl_rdata),
    .tbl_rvalid_o            (tbl_rvalid),
    .debug_mode_i            (dbg_mode),
    .prog_debug_clock_pin_i  (link_clk),
    .prog_debug_data_pin_i   (pin_in),
    .prog_debug_data_pin_o   (pin_out),
    .prog_debug_data_pin_oe_o(pin_oe),
    .boundary_port_enable_o  (port_en),
    .debug_channel_select_o  (chan),
    .debug_pin_reserve_o     (pin_res),
    .debug_ram_limit_o       (ram_lim),
    .odd_hyst_edge_select_o  (odd_edge),
    .odd_hyst_amount_o       (odd_amt),
    .odd_hyst_mv_o           (odd_mv),
    .even_hyst_edge_select_o (even_edge),
    .even_hyst_amount_o      (even_amt),
    .even_hyst_mv_o          (even_mv),
    .pwm_pins_port_ctrl_o    (pwm[2]),
    .pwm_high_active_high_o  (pwm[1]),
    .pwm_low_active_high_o   (pwm[0])
  );

  cdb_prog_model prog (
    .link_clk_o (link_clk),
    .host_data_o(host_d),
    .pin_data_i (pin_in),
    .dev_oe_i   (pin_oe)
  );

  // Core clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input cdb_word_t exp, input cdb_word_t got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Table read: one request cycle, answer exactly one cycle later
  task automatic rd_chk(input string what, input cdb_word_t addr, input cdb_word_t exp);
    @(posedge core_clk);
    tbl_rd   <= 1'b1;
    tbl_addr <= addr;
    @(posedge core_clk);
    tbl_rd <= 1'b0;
    #1;
    chk("read valid", 24'h00_0001, {23'h0, tbl_rvalid});
    chk(what, exp, tbl_rdata);
  endtask

  // Mode change is given time to reach the registered core outputs; the link side takes it in the next frame's lead-in clocks
  task automatic set_dbg(input logic v);
    @(posedge core_clk);
    dbg_mode <= v;
    repeat (20) @(posedge core_clk);
    #1;
  endtask

  // Link clock runs during reset since its side resets through a synchroniser
  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    prog.idle(4);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 80 us the frames need
  initial begin
    #300_000;
    n_fail++;
    wrap_up();
  end

  initial begin
    sys_rst   = 1'b1;
    tbl_rd    = 1'b0;
    tbl_addr  = 24'h00_0000;
    dbg_mode  = 1'b0;
    n_fail    = 0;
    cmp_count = 0;
    do_reset();
    rd_chk("debug word", `CDB_ADDR_DEBUG, 24'h00_00E3);
    rd_chk("cmp word", `CDB_ADDR_CMP, 24'h00_003F);
    rd_chk("power word", `CDB_ADDR_POWER_ON, 24'h00_00FF);
    rd_chk("id low", `CDB_ADDR_ID_LOW, ID_LO);
    rd_chk("id high", `CDB_ADDR_ID_HIGH, ID_HI);
    rd_chk("unmapped", 24'hF8_0020, 24'h00_0000);
    chk("ram limit", 24'h00_0000, {17'h0, ram_lim});
    // Every channel and amount code, each pass on pin pair k % 3
    for (int k = 0; k < 4; k++) begin
      wd = {16'hFFFF, 2'b00, k[0], 3'b111, k[1:0]};
      wc = {18'h3_FFFF, k[0], k[1:0], ~k[0], ~k[1:0]};
      prog.frame_write(k % 3, `CDB_ADDR_DEBUG, wd);
      prog.frame_write(k % 3, `CDB_ADDR_CMP, wc);
      prog.frame_write(k % 3, `CDB_ADDR_POWER_ON, {16'hFFFF, k[0], ~k[0], k[0], 5'h1F});
      rd_chk("debug word", `CDB_ADDR_DEBUG, wd & 24'h00_00E3);
      rd_chk("cmp word", `CDB_ADDR_CMP, wc & 24'h00_003F);
      chk("port enable", {23'h0, k[0]}, {23'h0, port_en});
      chk("channel", {22'h0, k[1:0]}, {22'h0, chan});
      chk("odd edge", {23'h0, k[0]}, {23'h0, odd_edge});
      chk("even edge", {23'h0, ~k[0]}, {23'h0, even_edge});
      chk("amounts", {20'h0, k[1:0], ~k[1:0]}, {20'h0, odd_amt, even_amt});
      chk("mv", {12'h0, mv_tab[k], mv_tab[3-k]}, {12'h0, odd_mv, even_mv});
      chk("pwm", {21'h0, k[0], ~k[0], k[0]}, {21'h0, pwm});
      set_dbg(1'b1);
      chk("pin reserve", {21'h0, (k == 0) ? 3'b000 : 3'(3'b001 << (3 - k))}, {21'h0, pin_res});
      chk("ram limit", 24'h00_0050, {17'h0, ram_lim});
      set_dbg(1'b0);
    end
    for (int u = 0; u < 4; u++) begin
      wd = 24'hA5_5A00 ^ 24'(u);
      prog.frame_write(u % 3, 24'(`CDB_ADDR_UNIT0 + 2 * u), wd);
      rd_chk("unit word", 24'(`CDB_ADDR_UNIT0 + 2 * u), wd);
    end
    prog.frame_read(2, `CDB_ADDR_UNIT2, wc, oe_clks);
    chk("link read", 24'hA5_5A02, wc);
    chk("reply clocks", 24'h00_0018, 24'(oe_clks));
    prog.frame_write(0, `CDB_ADDR_ID_LOW, 24'h00_0000);
    rd_chk("id low", `CDB_ADDR_ID_LOW, ID_LO);
    // Debugging on the second pair: the first pair must be ignored
    prog.frame_write(0, `CDB_ADDR_DEBUG, 24'h00_0022);
    set_dbg(1'b1);
    prog.frame_write(0, `CDB_ADDR_UNIT1, 24'h11_1111);
    rd_chk("unit word", `CDB_ADDR_UNIT1, 24'hA5_5A01);
    prog.frame_write(1, `CDB_ADDR_UNIT1, 24'h22_2222);
    rd_chk("unit word", `CDB_ADDR_UNIT1, 24'h22_2222);
    // A reply while debugging must come back on the selected pair only
    prog.frame_read(1, `CDB_ADDR_UNIT1, wc, oe_clks);
    chk("debug read", 24'h22_2222, wc);
    chk("debug reply clocks", 24'h00_0018, 24'(oe_clks));
    set_dbg(1'b0);
    // Second reset returns every word to its erased value
    do_reset();
    rd_chk("unit word", `CDB_ADDR_UNIT1, 24'hFF_FFFF);
    chk("channel", 24'h00_0003, {22'h0, chan});
    wrap_up();
  end
endmodule
